// >>> core/flash_command_interface.sv
`timescale 1ns/1ps
`include "flash_cmd_consts.svh"
module flash_command_interface
	import flash_cmd_pkg::*;
#(
	parameter int ADDR_W = 18,
	parameter int BLOCKS = 7,
	parameter int WINDOW_CYCLES = `WINDOW_US * `CLOCK_MHZ
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic clkEn,
	input wire logic wrStrobe,
	input wire logic [ADDR_W-1:0] wrAddr,
	input wire logic [15:0] wrData,
	input wire logic fetchFromFlash,
	input wire logic rdStrobe,
	input wire logic [ADDR_W-1:0] rdAddr,
	input wire logic eraseDone,
	output logic programStart,
	output logic [ADDR_W-1:0] targetLocation,
	output logic [15:0] writeValue,
	output logic eraseStart,
	output logic chipErase,
	output logic [BLOCKS-1:0] sectorSelect,
	output logic wipeActive,
	output logic wipePaused,
	output logic windowOpen,
	output logic protectionWrite,
	output logic [15:0] protectionValue,
	output logic protectionWriteError,
	output logic [15:0] lockRegister,
	output logic readLockRegister,
	output logic blockUnlockTemp,
	output logic codeUnlockTemp,
	output logic abortWipe
);
	seq_state_t state_reg, state_next;
	flash_cmd_if tif();
	wipe_window_timer #(.COUNT(WINDOW_CYCLES)) timer (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.clkEn(clkEn),
		.tmr(tif)
	);

	// decode of the current write
	wire w = wrStrobe && clkEn;
	wire [13:0] cAddr = wrAddr[13:0] & `ADDR_MASK;
	wire [7:0] cData = wrData[7:0];
	wire atUA = cAddr == `ADDR_UNLOCK_A;
	wire atUB = cAddr == `ADDR_UNLOCK_B;
	wire atPA = cAddr == `ADDR_PROT_A;
	wire atPB = cAddr == `ADDR_PROT_B;
	wire isReset = cData == `DATA_RESET;
	wire isSector = cData == `DATA_SECTOR;
	wire oddWord = wrAddr[1:0] == `ODD_WORD_LOW;
	wire rdOdd = rdAddr[1:0] == `ODD_WORD_LOW;
	wire codeUnlockWr = w && fetchFromFlash && wrData == `WORD_CODE_UNLOCK;
	wire codeRelockWr = w && fetchFromFlash && wrData == `WORD_CODE_RELOCK;
	wire codeWr = codeUnlockWr || codeRelockWr;
	wire [BLOCKS-1:0] blockOf = BLOCKS'(1) << wrAddr[ADDR_W-1:ADDR_W-3];
	wire [15:0] protectionValue_nextChk = wrData;
	wire protBad = |(protectionValue_nextChk & ~lockRegister);
	wire enterSector = state_reg == ST_EU2 && w && isSector;
	wire addSector = state_reg == ST_WINDOW && w && isSector;
	wire pauseWr = w && cData == `DATA_PAUSE && (wipeActive || windowOpen) && !wipePaused;
	wire resumeWr = w && isSector && wipePaused;

	always_comb begin
		state_next = state_reg;
		if (w && !codeWr) begin
			unique case (state_reg)
				ST_READ: state_next = (cData == `DATA_UNLOCK_A && atUA) ? ST_U1 :
					(cData == `DATA_UNLOCK_A && atPA) ? ST_P1 : ST_READ;
				ST_U1: state_next = (cData == `DATA_UNLOCK_B && atUB) ? ST_U2 : ST_READ;
				ST_U2: state_next = (cData == `DATA_PROGRAM && atUA) ? ST_PROG :
					(cData == `DATA_ERASE && atUA) ? ST_ERASE : ST_READ;
				ST_PROG: state_next = ST_READ;
				ST_ERASE: state_next = (cData == `DATA_UNLOCK_A && atUA) ? ST_EU1 : ST_READ;
				ST_EU1: state_next = (cData == `DATA_UNLOCK_B && atUB) ? ST_EU2 : ST_READ;
				ST_EU2: state_next = isSector ? ST_WINDOW : ST_READ;
				ST_WINDOW: state_next = isSector ? ST_WINDOW : ST_READ;
				ST_P1: state_next = (cData == `DATA_UNLOCK_B && atPB) ? ST_P2 : ST_READ;
				ST_P2: state_next = (cData == `DATA_PSET && atPA) ? ST_PSETW :
					(cData == `DATA_PREAD && atPA) ? ST_PREAD :
					(cData == `DATA_BUNLOCK && atPA) ? ST_BUNL : ST_READ;
				ST_PSETW: state_next = ST_READ;
				ST_PREAD: state_next = ST_READ;
				ST_BUNL: state_next = ST_READ;
				default: state_next = ST_READ;
			endcase
		end else if (state_reg == ST_WINDOW && tif.expired) begin
			state_next = ST_READ;
		end
	end

	assign tif.start = enterSector || addSector;
	assign tif.run = state_reg == ST_WINDOW && !pauseWr && !(w && !isSector);
	assign windowOpen = state_reg == ST_WINDOW;
	assign readLockRegister = state_reg == ST_PREAD && rdStrobe && rdOdd;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			state_reg <= ST_READ;
		else if (clkEn)
			state_reg <= state_next;
	end

	// command strobes and data toward the array
	wire progWr = w && state_reg == ST_PROG && !codeWr;
	wire psetWr = w && state_reg == ST_PSETW && oddWord;
	wire chipWr = w && state_reg == ST_EU2 && cData == `DATA_CHIP && atUA;
	wire resetWr = w && isReset;
	wire bunlWr = w && state_reg == ST_BUNL && isReset;
	wire captureWr = w && (state_reg == ST_PROG || state_reg == ST_PSETW);

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			programStart <= 1'b0;
			protectionWrite <= 1'b0;
			protectionWriteError <= 1'b0;
			abortWipe <= 1'b0;
		end else if (clkEn) begin
			programStart <= progWr;
			protectionWrite <= psetWr && !protBad;
			protectionWriteError <= psetWr && protBad;
			abortWipe <= resetWr && wipePaused;
		end
	end

	// captured word and location
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			targetLocation <= '0;
			writeValue <= 16'h0000;
			protectionValue <= 16'h0000;
		end else if (clkEn && captureWr) begin
			targetLocation <= wrAddr;
			writeValue <= wrData;
			protectionValue <= wrData;
		end
	end

	// wipe selection and start
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			eraseStart <= 1'b0;
			chipErase <= 1'b0;
			sectorSelect <= '0;
		end else if (clkEn) begin
			eraseStart <= tif.expired || chipWr;
			if (chipWr) begin
				chipErase <= 1'b1;
			end else if (enterSector) begin
				sectorSelect <= blockOf;
				chipErase <= 1'b0;
			end else if (addSector) begin
				sectorSelect <= sectorSelect | blockOf;
			end
		end
	end

	// wipe running and paused levels
	wire wipeGo = chipWr || tif.expired || (pauseWr && state_reg == ST_WINDOW);
	wire pauseEnd = resumeWr || eraseDone || resetWr;
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			wipeActive <= 1'b0;
			wipePaused <= 1'b0;
		end else if (clkEn) begin
			if (eraseDone)
				wipeActive <= 1'b0;
			if (wipeGo)
				wipeActive <= 1'b1;
			if (resetWr)
				wipeActive <= 1'b0;
			if (pauseWr)
				wipePaused <= 1'b1;
			else if (pauseEnd)
				wipePaused <= 1'b0;
		end
	end

	// temporary unlock levels
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			blockUnlockTemp <= 1'b0;
			codeUnlockTemp <= 1'b0;
		end else if (clkEn) begin
			if (bunlWr)
				blockUnlockTemp <= 1'b1;
			if (codeUnlockWr)
				codeUnlockTemp <= 1'b1;
			else if (codeRelockWr)
				codeUnlockTemp <= 1'b0;
		end
	end

	// lock register, loads PROT_RESET at reset and holds it
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			lockRegister <= `PROT_RESET;
		else if (clkEn)
			lockRegister <= lockRegister;
	end
endmodule

// >>> core/flash_cmd_consts.svh
`ifndef FLASH_CMD_CONSTS_SVH
`define FLASH_CMD_CONSTS_SVH
`define ADDR_MASK 14'h3fff
`define ADDR_UNLOCK_A 14'h1554
`define ADDR_UNLOCK_B 14'h2aa8
`define ADDR_PROT_A 14'h2a54
`define ADDR_PROT_B 14'h15a8
`define DATA_UNLOCK_A 8'ha8
`define DATA_UNLOCK_B 8'h54
`define DATA_RESET 8'hf0
`define DATA_PROGRAM 8'ha0
`define DATA_ERASE 8'h80
`define DATA_SECTOR 8'h30
`define DATA_CHIP 8'h10
`define DATA_PAUSE 8'hb0
`define DATA_PSET 8'hc0
`define DATA_PREAD 8'h90
`define DATA_BUNLOCK 8'hc1
`define WORD_CODE_UNLOCK 16'hffff
`define WORD_CODE_RELOCK 16'hfffb
`define ODD_WORD_LOW 2'h2
`define CODE_PROT_BIT 15
`define WINDOW_US 96
`define CLOCK_MHZ 100
`define PROT_RESET 16'hffff
`endif

// >>> core/flash_cmd_pkg.sv
package flash_cmd_pkg;
	typedef enum logic [3:0] {
		ST_READ = 4'h0,
		ST_U1 = 4'h1,
		ST_U2 = 4'h3,
		ST_ERASE = 4'h2,
		ST_EU1 = 4'h6,
		ST_EU2 = 4'h7,
		ST_PROG = 4'h5,
		ST_P1 = 4'h4,
		ST_P2 = 4'hc,
		ST_PCMD = 4'hd,
		ST_PSETW = 4'hf,
		ST_PREAD = 4'he,
		ST_BUNL = 4'ha,
		ST_WINDOW = 4'hb
	} seq_state_t;
endpackage

// >>> core/flash_cmd_if.sv
`timescale 1ns/1ps
interface flash_cmd_if;
	logic start;
	logic run;
	logic expired;
	modport owner(output start, output run, input expired);
	modport timer(input start, input run, output expired);
endinterface

// >>> core/wipe_window_timer.sv
`timescale 1ns/1ps
`include "flash_cmd_consts.svh"
module wipe_window_timer #(
	parameter int COUNT = `WINDOW_US * `CLOCK_MHZ
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic clkEn,
	flash_cmd_if.timer tmr
);
	logic [15:0] count_reg;
	wire atEnd = (count_reg == 16'h0001);
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			count_reg <= 16'h0000;
		end else if (clkEn) begin
			if (tmr.start)
				count_reg <= 16'(COUNT);
			else if (!tmr.run)
				count_reg <= 16'h0000;
			else if (count_reg != 16'h0000)
				count_reg <= count_reg - 16'h0001;
		end
	end
	assign tmr.expired = tmr.run && !tmr.start && atEnd;
endmodule

// >>> bench/flash_cmd_props.sv
`timescale 1ns/1ps
module flash_cmd_props #(parameter int ADDR_W = 18) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic clkEn,
	input wire logic wrStrobe,
	input wire logic [ADDR_W-1:0] wrAddr,
	input wire logic [15:0] wrData,
	input wire logic fetchFromFlash,
	input wire logic [ADDR_W-1:0] rdAddr,
	input wire logic programStart,
	input wire logic [ADDR_W-1:0] targetLocation,
	input wire logic eraseStart,
	input wire logic chipErase,
	input wire logic wipeActive,
	input wire logic protectionWrite,
	input wire logic [15:0] protectionValue,
	input wire logic protectionWriteError,
	input wire logic [15:0] lockRegister,
	input wire logic readLockRegister,
	input wire logic codeUnlockTemp
);
	wire w = wrStrobe && clkEn;
	wire [13:0] a = wrAddr[13:0];
	wire [7:0] d = wrData[7:0];
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	sequence cmd(logic [13:0] ca, logic [7:0] cd);
		w && a == ca && d == cd;
	endsequence
	sequence unl;
		cmd(14'h1554, 8'ha8) ##1 cmd(14'h2aa8, 8'h54);
	endsequence
	sequence punl;
		cmd(14'h2a54, 8'ha8) ##1 cmd(14'h15a8, 8'h54);
	endsequence
	AST_PROG: assert property (unl ##1 cmd(14'h1554, 8'ha0) ##1 w
		|=> programStart && targetLocation == $past(wrAddr)) else $error("word write did not start");
	AST_CHIP: assert property (unl ##1 cmd(14'h1554, 8'h80) ##1 unl ##1 cmd(14'h1554, 8'h10)
		|=> eraseStart && chipErase) else $error("chip erase did not start");
	AST_PSET: assert property (punl ##1 cmd(14'h2a54, 8'hc0) ##1 w && wrAddr[1:0] == 2'h2
		|=> protectionWrite && protectionValue == $past(wrData) || protectionWriteError) else $error("no lock write");
	AST_ABORT: assert property (w && d == 8'hf0 |=> !wipeActive) else $error("wipe kept running");
	AST_CUNL: assert property (w && wrData == 16'hffff && fetchFromFlash |=> codeUnlockTemp)
		else $error("code unlock missed");
	AST_CREL: assert property (w && wrData == 16'hfffb && fetchFromFlash |=> !codeUnlockTemp)
		else $error("code relock missed");
	AST_NOFETCH: assert property (w && !fetchFromFlash && !codeUnlockTemp |=> !codeUnlockTemp)
		else $error("code unlocked from outside flash");
	AST_ODD: assert property (readLockRegister |-> rdAddr[1:0] == 2'h2) else $error("lock read at even word");
	AST_LOCK: assert property ($stable(lockRegister)) else $error("lock register changed");
endmodule
bind flash_command_interface flash_cmd_props #(.ADDR_W(ADDR_W)) props (.*);

// >>> bench/cpu_port_model.sv
`timescale 1ns/1ps
module cpu_port_model (
	input wire logic ref_clk,
	output logic wrStrobe,
	output logic [17:0] wrAddr,
	output logic [15:0] wrData,
	output logic fetchFromFlash,
	output logic rdStrobe,
	output logic [17:0] rdAddr
);
	initial begin
		{wrStrobe, wrAddr, wrData, fetchFromFlash, rdStrobe, rdAddr} = '0;
	end
	// one write held across the taking edge
	task automatic wr(input logic [17:0] a, input logic [15:0] d, input logic f = 1'b0);
		#1 wrStrobe = 1'b1;
		rdStrobe = 1'b0;
		wrAddr = a;
		wrData = d;
		fetchFromFlash = f;
		@(posedge ref_clk);
	endtask
	task automatic rd(input logic [17:0] a);
		#1 rdStrobe = 1'b1;
		wrStrobe = 1'b0;
		rdAddr = a;
		@(posedge ref_clk);
	endtask
	// released bus shows the inverse of the last value
	task automatic idle();
		#1 wrStrobe = 1'b0;
		rdStrobe = 1'b0;
		wrAddr = ~wrAddr;
		wrData = ~wrData;
		@(posedge ref_clk);
	endtask
endmodule

// >>> bench/flash_command_interface_tb.sv
`timescale 1ns/1ps
module flash_command_interface_tb;
	logic ref_clk = 0, reset_n = 0, clkEn = 1, eraseDone = 0;
	logic wrStrobe, fetchFromFlash, rdStrobe;
	logic [17:0] wrAddr, rdAddr, targetLocation;
	logic [15:0] wrData, writeValue, protectionValue, lockRegister;
	logic [6:0] sectorSelect;
	logic programStart, eraseStart, chipErase, wipeActive, wipePaused, windowOpen, protectionWrite;
	logic protectionWriteError, readLockRegister, blockUnlockTemp, codeUnlockTemp, abortWipe;
	int failures = 0, n_compared = 0, cycles = 0, i;
	always #5 ref_clk = ~ref_clk;
	flash_command_interface #(.WINDOW_CYCLES(20)) uut (.*);
	cpu_port_model p (.*);
	task automatic chk(input string n, input logic [17:0] e, input logic [17:0] s);
		n_compared++;
		if (s !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic complete_run();
		$display("compared %0d failed %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			complete_run();
		end
	end
	task automatic unl(input logic [17:0] hi = 0);
		p.wr(18'h01554 | hi, 16'h00a8);
		p.wr(18'h02aa8 | hi, 16'h0054);
	endtask
	task automatic punl();
		p.wr(18'h02a54, 16'h00a8);
		p.wr(18'h015a8, 16'h0054);
	endtask
	task automatic t_prog();
		unl(18'h3c000);
		p.wr(18'h0d554, 16'h12a0);
		p.wr(18'h2b00e, 16'h5a3c);
		#1 chk("prog", 1, programStart);
		chk("loc", 18'h2b00e, targetLocation);
		chk("val", 16'h5a3c, writeValue);
		unl();
		p.wr(18'h02aa8, 16'h00a0);
		p.wr(18'h00100, 16'h1111);
		#1 chk("prog", 0, programStart);
		unl();
		p.wr(18'h00000, 16'h0077);
		p.wr(18'h01554, 16'h00a0);
		p.wr(18'h00100, 16'h1111);
		#1 chk("prog", 0, programStart);
		p.idle();
	endtask
	task automatic t_erase();
		unl();
		p.wr(18'h01554, 16'h0080);
		unl();
		p.wr(18'h01554, 16'h0010);
		#1 chk("chip", 1, chipErase && eraseStart);
		p.wr(18'h00000, 16'h00f0);
		#1 chk("active", 0, wipeActive);
		unl();
		p.wr(18'h01554, 16'h0080);
		unl();
		p.wr(18'h18000, 16'h0030);
		p.idle();
		#1 chk("window", 1, windowOpen);
		for (i = 0; i < 40 && eraseStart !== 1'b1; i++) begin
			p.idle();
			#1;
		end
		chk("late", 1, i > 10 && i < 40);
		chk("sector", 7'h08, sectorSelect);
		p.wr(18'h00022, 16'h00b0);
		#1 chk("paused", 1, wipePaused);
		p.wr(18'h00444, 16'h0030);
		#1 chk("paused", 0, wipePaused);
		p.wr(18'h00022, 16'h00b0);
		p.wr(18'h00000, 16'h00f0);
		#1 chk("abort", 1, abortWipe);
		chk("active", 0, wipeActive);
		unl();
		p.wr(18'h01554, 16'h0080);
		unl();
		p.wr(18'h00000, 16'h0030);
		p.wr(18'h00000, 16'h00b0);
		#1 chk("winPause", 1, wipeActive && wipePaused && !windowOpen);
		p.wr(18'h00000, 16'h0030);
		#1 eraseDone = 1'b1;
		p.idle();
		#1 eraseDone = 1'b0;
		chk("done", 0, wipeActive || wipePaused);
	endtask
	task automatic t_prot();
		punl();
		p.wr(18'h02a54, 16'h0090);
		p.rd(18'h00006);
		#1 chk("rdLock", 1, readLockRegister);
		chk("lock", 16'hffff, lockRegister);
		p.rd(18'h00004);
		#1 chk("rdLock", 0, readLockRegister);
		p.wr(18'h00000, 16'h00f0);
		punl();
		p.wr(18'h02a54, 16'h00c1);
		p.wr(18'h00000, 16'h00f0);
		#1 chk("blkUnl", 1, blockUnlockTemp);
		punl();
		p.wr(18'h02a54, 16'h00c0);
		p.wr(18'h00002, 16'h7ffe);
		#1 chk("pwr", 1, protectionWrite);
		chk("pval", 16'h7ffe, protectionValue);
		chk("perr", 0, protectionWriteError);
		p.idle();
	endtask
	task automatic t_code();
		p.wr(18'h00100, 16'hffff, 1'b0);
		#1 chk("code", 0, codeUnlockTemp);
		clkEn = 1'b0;
		p.wr(18'h00100, 16'hffff, 1'b1);
		#1 chk("frozen", 0, codeUnlockTemp);
		clkEn = 1'b1;
		p.wr(18'h00100, 16'hffff, 1'b1);
		#1 chk("code", 1, codeUnlockTemp);
		p.wr(18'h00100, 16'hfffb, 1'b1);
		#1 chk("code", 0, codeUnlockTemp);
		p.idle();
		#1 reset_n = 1'b0;
		p.idle();
		#1 reset_n = 1'b1;
		chk("rstUnl", 0, blockUnlockTemp);
		p.idle();
	endtask
	initial begin
		repeat (12) @(posedge ref_clk);
		#1 reset_n = 1;
		@(posedge ref_clk);
		t_prog();
		t_erase();
		t_prot();
		t_code();
		complete_run();
	end
endmodule
